// *** src/dacc_pkg.sv ***
// Package for the dual channel converter control block.
// Assumes one 100 MHz core clock; the conversion rates are derived from it.
package dacc_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL_A = 5'h00;
   localparam logic [4:0] OFS_CTRL_B = 5'h04;
   localparam logic [4:0] OFS_DATA_A = 5'h08;
   localparam logic [4:0] OFS_DATA_B = 5'h0c;
   localparam logic [4:0] OFS_CLK = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;
   localparam logic [4:0] OFS_MASK = 5'h18;
   localparam logic [4:0] OFS_CODES = 5'h1c;
   // Control field positions, same layout in both channel controls
   localparam int BIT_EN = 0;
   localparam int BIT_IO_EN = 1;
   localparam int BIT_MODE = 2;
   localparam int BIT_DMA_EN = 3;
   localparam int BIT_TRIG_EN = 4;
   localparam int BIT_WAVE_LO = 5;
   localparam int BIT_RANGE_LO = 7;
   localparam int BIT_REF_SEL = 9;
   localparam int CTRL_W = 10;
   localparam int CODE_W = 10;
   localparam int CODES_B_LO = 16;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
   localparam logic [1:0] CLK_SEL_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   // Wave select encodings
   localparam logic [1:0] WAVE_SINE = 2'h2;
   localparam logic [1:0] WAVE_DIFF = 2'h3;
   // Decoded output ranges
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_MID = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Conversion rates and divider counts
   localparam longint CORE_CLK_HZ = 100000000;
   localparam longint RATE0_HZ = 62500;
   localparam longint RATE1_HZ = 125000;
   localparam longint RATE2_HZ = 250000;
   localparam longint RATE3_HZ = 500000;
   localparam int DIV_W = 11;
   localparam logic [DIV_W-1:0] DIV0 = DIV_W'(CORE_CLK_HZ / RATE0_HZ);
   localparam logic [DIV_W-1:0] DIV1 = DIV_W'(CORE_CLK_HZ / RATE1_HZ);
   localparam logic [DIV_W-1:0] DIV2 = DIV_W'(CORE_CLK_HZ / RATE2_HZ);
   localparam logic [DIV_W-1:0] DIV3 = DIV_W'(CORE_CLK_HZ / RATE3_HZ);
   localparam int SINE_STEPS = 16;
   localparam int PHASE_W = 4;
endpackage

// *** src/dacc_sine_rom.sv ***
// Sixteen entry sine table with a registered read port.
// Assumes the address is a 4-bit phase; data appear one clock later.
`timescale 1ns/100ps
module dacc_sine_rom (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic [dacc_pkg::PHASE_W-1:0] phase_in,
   output logic [dacc_pkg::CODE_W-1:0] sample_out
);
   // One period, starting at zero degrees on mid scale
   localparam logic [dacc_pkg::CODE_W-1:0] TABLE [dacc_pkg::SINE_STEPS] = '{
      10'h200, 10'h2c4, 10'h369, 10'h3d8, 10'h3ff, 10'h3d8, 10'h369, 10'h2c4,
      10'h200, 10'h13c, 10'h097, 10'h028, 10'h001, 10'h028, 10'h097, 10'h13c};

   // Registered read keeps the table off the output path
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sample_out <= dacc_pkg::CODE_RST;
      end else begin
         sample_out <= TABLE[phase_in];
      end
   end
endmodule

// *** src/dacc_top.sv ***
// Control logic for a two channel 10-bit string converter.
// Assumes an AXI4-Lite master, synchronous trigger pulses and one core clock.
`timescale 1ns/100ps
module dacc_top (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [4:0] s_axi_awaddr_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [4:0] s_axi_araddr_in,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   input wire logic [1:0] trig_in,
   output logic [1:0] channel_dma_request_out,
   input wire logic [1:0] channel_dma_ack_in,
   output logic [9:0] channel_a_output_code_out,
   output logic [9:0] channel_b_output_code_out,
   output logic [1:0] power_on_out,
   output logic channel_a_output_pad_en_out,
   output logic channel_b_output_pad_en_out,
   output logic differential_out,
   output logic [1:0] range_out,
   output logic ref_external_out,
   output logic conv_tick_out,
   output logic irq_out
);
   localparam int W = dacc_pkg::CODE_W;
   logic [dacc_pkg::CTRL_W-1:0] ctrl_ff [2];
   logic [W-1:0] data_ff [2];
   logic [W-1:0] code_ff [2];
   logic [1:0] clk_sel_ff;
   logic [1:0] status_ff;
   logic [1:0] mask_ff;
   logic [1:0] dma_req_ff;
   logic [dacc_pkg::DIV_W-1:0] div_cnt_ff;
   logic [dacc_pkg::DIV_W-1:0] div_max;
   logic tick;
   logic [dacc_pkg::PHASE_W-1:0] phase_ff;
   logic [W-1:0] sine_q;
   logic sine_on;
   logic diff_on;
   logic wr_go;
   logic rd_go;
   logic [1:0] data_wr;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [31:0] nxt_rdata;
   logic nxt_rmapped;
   logic [1:0] range_ff;
   logic diff_ff;
   logic [1:0] pad_ff;

   // Write taken only when address and data are both present
   assign wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_ff;
   assign rd_go = s_axi_arvalid_in && !rvalid_ff;
   assign s_axi_awready_out = wr_go;
   assign s_axi_wready_out = wr_go;
   assign s_axi_arready_out = rd_go;
   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign data_wr[0] = wr_go && s_axi_awaddr_in == dacc_pkg::OFS_DATA_A;
   assign data_wr[1] = wr_go && s_axi_awaddr_in == dacc_pkg::OFS_DATA_B;

   // Mode decode shared by both channels
   assign sine_on = ctrl_ff[0][dacc_pkg::BIT_WAVE_LO +: 2] == dacc_pkg::WAVE_SINE;
   assign diff_on = ctrl_ff[1][dacc_pkg::BIT_WAVE_LO +: 2] == dacc_pkg::WAVE_DIFF;

   // Register writes; low byte lanes only since fields sit below bit 16
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         ctrl_ff[0] <= dacc_pkg::CTRL_RST;
         ctrl_ff[1] <= dacc_pkg::CTRL_RST;
         data_ff[0] <= dacc_pkg::CODE_RST;
         data_ff[1] <= dacc_pkg::CODE_RST;
         clk_sel_ff <= dacc_pkg::CLK_SEL_RST;
         mask_ff <= dacc_pkg::MASK_RST;
      end else if (wr_go) begin
         case (s_axi_awaddr_in)
            dacc_pkg::OFS_CTRL_A, dacc_pkg::OFS_CTRL_B: begin
               if (s_axi_wstrb_in[0]) begin
                  ctrl_ff[s_axi_awaddr_in[2]][7:0] <= s_axi_wdata_in[7:0];
               end
               if (s_axi_wstrb_in[1]) begin
                  ctrl_ff[s_axi_awaddr_in[2]][9:8] <= s_axi_wdata_in[9:8];
               end
            end
            dacc_pkg::OFS_DATA_A, dacc_pkg::OFS_DATA_B: begin
               if (s_axi_wstrb_in[0]) begin
                  data_ff[s_axi_awaddr_in[2]][7:0] <= s_axi_wdata_in[7:0];
               end
               if (s_axi_wstrb_in[1]) begin
                  data_ff[s_axi_awaddr_in[2]][9:8] <= s_axi_wdata_in[9:8];
               end
            end
            dacc_pkg::OFS_CLK: begin
               if (s_axi_wstrb_in[0]) begin
                  clk_sel_ff <= s_axi_wdata_in[1:0];
               end
            end
            dacc_pkg::OFS_MASK: begin
               if (s_axi_wstrb_in[0]) begin
                  mask_ff <= s_axi_wdata_in[1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Write response; read-only offsets and unmapped ones above OFS_CLK answer with an error
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= dacc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= (s_axi_awaddr_in <= dacc_pkg::OFS_CLK || s_axi_awaddr_in == dacc_pkg::OFS_MASK)
            ? dacc_pkg::RESP_OKAY : dacc_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_ff <= 1'b0;
      end
   end

   // Read data selection
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rmapped = 1'b1;
      case (s_axi_araddr_in)
         dacc_pkg::OFS_CTRL_A: nxt_rdata[9:0] = ctrl_ff[0];
         dacc_pkg::OFS_CTRL_B: nxt_rdata[9:0] = ctrl_ff[1];
         dacc_pkg::OFS_DATA_A: nxt_rdata[9:0] = data_ff[0];
         dacc_pkg::OFS_DATA_B: nxt_rdata[9:0] = data_ff[1];
         dacc_pkg::OFS_CLK: nxt_rdata[1:0] = clk_sel_ff;
         dacc_pkg::OFS_STATUS: nxt_rdata[1:0] = status_ff;
         dacc_pkg::OFS_MASK: nxt_rdata[1:0] = mask_ff;
         dacc_pkg::OFS_CODES: begin
            nxt_rdata[W-1:0] = code_ff[0];
            nxt_rdata[dacc_pkg::CODES_B_LO +: W] = code_ff[1];
         end
         default: nxt_rmapped = 1'b0;
      endcase
   end

   // Read channel, answer one cycle after the address is taken
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= dacc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rmapped ? dacc_pkg::RESP_OKAY : dacc_pkg::RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Rate divider; a rate change restarts the count at the next wrap
   always_comb begin
      case (clk_sel_ff)
         2'h0: div_max = dacc_pkg::DIV0 - 11'h001;
         2'h1: div_max = dacc_pkg::DIV1 - 11'h001;
         2'h2: div_max = dacc_pkg::DIV2 - 11'h001;
         default: div_max = dacc_pkg::DIV3 - 11'h001;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         div_cnt_ff <= '0;
      end else if (div_cnt_ff >= div_max) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 11'h001;
      end
   end
   assign tick = div_cnt_ff >= div_max;
   assign conv_tick_out = tick;

   // Sine phase, parked at zero degrees while generation is off
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in || !sine_on || !ctrl_ff[0][dacc_pkg::BIT_EN]) begin
         phase_ff <= '0;
      end else if (tick) begin
         phase_ff <= phase_ff + 4'h1;
      end
   end

   dacc_sine_rom u_rom (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .phase_in(phase_ff),
      .sample_out(sine_q)
   );

   // Code loading per channel; sine first, then trigger, sync, async
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         code_ff[0] <= dacc_pkg::CODE_RST;
         code_ff[1] <= dacc_pkg::CODE_RST;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (!ctrl_ff[c][dacc_pkg::BIT_EN]) begin
               code_ff[c] <= dacc_pkg::CODE_RST;
            end else if (sine_on && c == 0) begin
               code_ff[c] <= sine_q;
            end else if (sine_on && diff_on && ctrl_ff[0][dacc_pkg::BIT_EN]) begin
               code_ff[c] <= ~sine_q;
            end else if (ctrl_ff[c][dacc_pkg::BIT_TRIG_EN]) begin
               if (trig_in[c]) begin
                  code_ff[c] <= data_ff[c];
               end
            end else if (ctrl_ff[c][dacc_pkg::BIT_MODE]) begin
               if (tick) begin
                  code_ff[c] <= data_ff[c];
               end
            end else begin
               code_ff[c] <= data_ff[c];
            end
         end
      end
   end
   assign channel_a_output_code_out = code_ff[0];
   assign channel_b_output_code_out = code_ff[1];

   // DMA requests; a new request beats the data write that clears it
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         dma_req_ff <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (tick && ctrl_ff[c][dacc_pkg::BIT_EN] && ctrl_ff[c][dacc_pkg::BIT_DMA_EN]) begin
               dma_req_ff[c] <= 1'b1;
            end else if (data_wr[c] || channel_dma_ack_in[c]) begin
               dma_req_ff[c] <= 1'b0;
            end
         end
      end
   end
   assign channel_dma_request_out = dma_req_ff;

   // Conversion done status; a read clears it unless a tick lands then
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         status_ff <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (tick && ctrl_ff[c][dacc_pkg::BIT_EN]) begin
               status_ff[c] <= 1'b1;
            end else if (rd_go && s_axi_araddr_in == dacc_pkg::OFS_STATUS) begin
               status_ff[c] <= 1'b0;
            end
         end
      end
   end
   assign irq_out = |(status_ff & mask_ff);

   // Analog side controls, registered to keep the pads glitch free
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         range_ff <= dacc_pkg::RANGE_LOW;
         diff_ff <= 1'b0;
         pad_ff <= 2'h0;
      end else begin
         case (ctrl_ff[0][dacc_pkg::BIT_RANGE_LO +: 2])
            2'h0: range_ff <= dacc_pkg::RANGE_LOW;
            2'h1, 2'h2: range_ff <= dacc_pkg::RANGE_MID;
            default: range_ff <= dacc_pkg::RANGE_HIGH;
         endcase
         diff_ff <= diff_on;
         for (int c = 0; c < 2; c++) begin
            // Differential drives both pads of enabled channels
            pad_ff[c] <= ctrl_ff[c][dacc_pkg::BIT_EN]
               && (ctrl_ff[c][dacc_pkg::BIT_IO_EN] || diff_on);
         end
      end
   end
   assign range_out = range_ff;
   assign ref_external_out = ctrl_ff[0][dacc_pkg::BIT_REF_SEL];
   assign differential_out = diff_ff;
   assign channel_a_output_pad_en_out = pad_ff[0];
   assign channel_b_output_pad_en_out = pad_ff[1];
   assign power_on_out = {ctrl_ff[1][dacc_pkg::BIT_EN], ctrl_ff[0][dacc_pkg::BIT_EN]};

   // Checks
   logic a_en;
   logic b_sync;
   logic a_async;
   assign a_en = ctrl_ff[0][dacc_pkg::BIT_EN];
   assign b_sync = ctrl_ff[1][dacc_pkg::BIT_EN] && !(sine_on && diff_on && a_en)
      && !ctrl_ff[1][dacc_pkg::BIT_TRIG_EN] && ctrl_ff[1][dacc_pkg::BIT_MODE];
   assign a_async = a_en && !sine_on && !ctrl_ff[0][dacc_pkg::BIT_TRIG_EN]
      && !ctrl_ff[0][dacc_pkg::BIT_MODE];
   sequence s_diff_sine;
      sine_on && diff_on && a_en && ctrl_ff[1][dacc_pkg::BIT_EN];
   endsequence

   AST_DIFF: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      diff_on |=> differential_out) else $error("differential not set");
   AST_PAD: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (!diff_on && !ctrl_ff[0][dacc_pkg::BIT_IO_EN]) |=> !channel_a_output_pad_en_out)
      else $error("pad A driven without enable");
   AST_OFF: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      !ctrl_ff[1][dacc_pkg::BIT_EN] |=> channel_b_output_code_out == 10'h000)
      else $error("disabled channel B converts");
   AST_RANGE: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      ctrl_ff[0][dacc_pkg::BIT_RANGE_LO +: 2] == 2'h2 |=> range_out == dacc_pkg::RANGE_MID)
      else $error("range 10 not mid");
   AST_TICK: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      tick |=> !tick [*8]) else $error("ticks too close");
   AST_SYNC: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (b_sync && !tick) [*2] |-> $stable(channel_b_output_code_out))
      else $error("sync code moved off tick");
   AST_ASYNC: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      a_async |=> channel_a_output_code_out == $past(data_ff[0]))
      else $error("async code not last write");
   AST_SINE0: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $rose(sine_on && a_en) |-> phase_ff == 4'h0) else $error("sine not at zero");
   AST_INV: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      s_diff_sine ##1 s_diff_sine |-> channel_b_output_code_out == ~channel_a_output_code_out)
      else $error("B not inverted sine");
   AST_DMA: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (tick && a_en && ctrl_ff[0][dacc_pkg::BIT_DMA_EN]) |=> channel_dma_request_out[0])
      else $error("no DMA request");
   AST_TRIG: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (a_en && !sine_on && ctrl_ff[0][dacc_pkg::BIT_TRIG_EN] && !trig_in[0])
      |=> $stable(channel_a_output_code_out)) else $error("code moved without trigger");
endmodule

// *** tb/dacc_dma_peer.sv ***
// DMA engine model that answers each converter data request with an ack pulse.
// Assumes requests are level signals that drop one cycle after the ack is seen.
`timescale 1ns/100ps
module dacc_dma_peer (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic [1:0] req_in,
   input wire logic [3:0] delay_in,
   output logic [1:0] ack_out
);
   logic [3:0] wait_ff [2];

   // Per channel wait, then one ack pulse; a slow delay keeps the request visible
   always_ff @(posedge core_clk_in) begin
      for (int i = 0; i < 2; i++) begin
         ack_out[i] <= 1'b0;
         wait_ff[i] <= 4'h0;
         if (nrst_in && req_in[i] && !ack_out[i]) begin
            if (wait_ff[i] == delay_in) begin
               ack_out[i] <= 1'b1;
            end else begin
               wait_ff[i] <= wait_ff[i] + 4'h1;
            end
         end
      end
   end
endmodule

// *** tb/dual_channel_dac_control_test.sv ***
// Self-checking bench for the converter control: reset, async and range, rate, sync DMA, trigger and sine tests over AXI4-Lite.
// Assumes the DMA peer model and a 100 MHz core clock; bready/rready held high.
`timescale 1ns/100ps
module dual_channel_dac_control_test;
   logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
   logic bready = 1'b0, rready = 1'b0;
   logic [4:0] awa = 5'h00, ara = 5'h00;
   logic [31:0] wd = 32'h0, rdat, v;
   logic [1:0] trig = 2'h0, ack, req, br, rr, pwr, rng;
   logic [3:0] dly = 4'h0;
   logic awr, wr_o, bv, arr, rv, pad_a, pad_b, diff, refx, tick, irq;
   logic [9:0] code_a, code_b;
   logic [9:0] smp [17];
   logic [31:0] ca, cb;
   int failures = 0, num_checks = 0, cycles = 0, n;
   assign ca = 32'(code_a);
   assign cb = 32'(code_b);

   dacc_top dut (.core_clk_in(clk), .nrst_in(nrst), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_o), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_bresp_out(br),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rr), .trig_in(trig), .channel_dma_request_out(req),
      .channel_dma_ack_in(ack), .channel_a_output_code_out(code_a),
      .channel_b_output_code_out(code_b), .power_on_out(pwr),
      .channel_a_output_pad_en_out(pad_a), .channel_b_output_pad_en_out(pad_b),
      .differential_out(diff), .range_out(rng), .ref_external_out(refx),
      .conv_tick_out(tick), .irq_out(irq));

   dacc_dma_peer peer (.core_clk_in(clk), .nrst_in(nrst), .req_in(req), .delay_in(dly),
      .ack_out(ack));

   // Free running clock
   always #5 clk = ~clk;

   // Watchdog, generous against the roughly 10k cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         end_sim();
      end
   end

   task end_sim;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task step(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Address and data offered together, response checked against expectation
   task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      bready <= 1'b1;
      do @(posedge clk); while (awr !== 1'b1 || wr_o !== 1'b1);
      awv <= 1'b0;
      wv <= 1'b0;
      while (bv !== 1'b1) @(posedge clk);
      chk("bresp", 32'(br), 32'(er));
   endtask

   task rd(input logic [4:0] a, output logic [31:0] d);
      arv <= 1'b1;
      ara <= a;
      rready <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge clk);
      d = rdat;
      chk("rresp", 32'(rr), 32'(dacc_pkg::RESP_OKAY));
   endtask

   // Returns at the edge that takes a conversion tick
   task wait_tick;
      do @(posedge clk); while (tick !== 1'b1);
   endtask

   // Main sequence
   initial begin
      step(10);
      nrst <= 1'b1;
      step(1);
      for (int i = 0; i < 8; i++) begin
         rd(5'(i * 4), v);
         chk("reset reg", v, 32'h0);
      end
      chk("power reset", 32'(pwr), 32'h0);
      wr(dacc_pkg::OFS_STATUS, 32'h3, dacc_pkg::RESP_SLVERR);
      wr(dacc_pkg::OFS_CODES, 32'h3, dacc_pkg::RESP_SLVERR);
      $display("test reset done");
      // Async code, pad off, ranges counted down so channel B range is shown inert
      wr(dacc_pkg::OFS_CTRL_A, 32'h1, dacc_pkg::RESP_OKAY);
      wr(dacc_pkg::OFS_DATA_A, 32'h155, dacc_pkg::RESP_OKAY);
      step(3);
      chk("code a async", ca, 32'h155);
      chk("pad a off", 32'(pad_a), 32'h0);
      chk("power a only", 32'(pwr), 32'h1);
      chk("single ended", 32'(diff), 32'h0);
      rd(dacc_pkg::OFS_CODES, v);
      chk("codes", v, 32'h155);
      for (int r = 3; r >= 0; r--) begin
         wr(dacc_pkg::OFS_CTRL_A, 32'h3 | (r << 7) | ((r & 1) << 9), dacc_pkg::RESP_OKAY);
         step(2);
         chk("range", 32'(rng), r == 0 ? 32'(dacc_pkg::RANGE_LOW) :
            r == 3 ? 32'(dacc_pkg::RANGE_HIGH) : 32'(dacc_pkg::RANGE_MID));
         chk("ref", 32'(refx), 32'(r & 1));
         chk("pad a on", 32'(pad_a), 32'h1);
      end
      wr(dacc_pkg::OFS_CTRL_B, 32'h180, dacc_pkg::RESP_OKAY);
      step(2);
      chk("range shared", 32'(rng), 32'(dacc_pkg::RANGE_LOW));
      $display("test async and range done");
      // Second tick gap after each rate change, 1600 cycles halving per step
      for (int c = 0; c < 4; c++) begin
         wr(dacc_pkg::OFS_CLK, 32'(c), dacc_pkg::RESP_OKAY);
         wait_tick();
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (tick !== 1'b1);
         chk("tick gap", 32'(n), 32'(dacc_pkg::DIV0) >> c);
      end
      $display("test rates done");
      // Channel B sync with DMA and a slow ack, interrupt on its status bit
      wr(dacc_pkg::OFS_MASK, 32'h2, dacc_pkg::RESP_OKAY);
      wr(dacc_pkg::OFS_CTRL_B, 32'hf, dacc_pkg::RESP_OKAY);
      dly <= 4'h9;
      wait_tick();
      step(3);
      chk("dma req b", 32'(req), 32'h2);
      chk("pad b on", 32'(pad_b), 32'h1);
      chk("irq set", 32'(irq), 32'h1);
      step(12);
      chk("dma req acked", 32'(req), 32'h0);
      rd(dacc_pkg::OFS_STATUS, v);
      chk("status", v, 32'h3);
      step(2);
      chk("irq cleared", 32'(irq), 32'h0);
      wr(dacc_pkg::OFS_DATA_B, 32'h2aa, dacc_pkg::RESP_OKAY);
      step(3);
      chk("sync hold", cb, 32'h0);
      wait_tick();
      step(3);
      chk("sync load", cb, 32'h2aa);
      $display("test sync dma done");
      // Trigger mode on A: neither write nor tick loads, only the pulse
      wr(dacc_pkg::OFS_CTRL_A, 32'h13, dacc_pkg::RESP_OKAY);
      wr(dacc_pkg::OFS_DATA_A, 32'h0ab, dacc_pkg::RESP_OKAY);
      step(3);
      chk("trig hold", ca, 32'h155);
      wait_tick();
      step(3);
      chk("trig hold tick", ca, 32'h155);
      trig <= 2'h1;
      step(1);
      trig <= 2'h0;
      step(3);
      chk("trig load", ca, 32'h0ab);
      $display("test trigger done");
      // Sine on A, one sample per tick, sixteen per period
      wait_tick();
      wr(dacc_pkg::OFS_CTRL_A, 32'h41, dacc_pkg::RESP_OKAY);
      step(3);
      smp[0] = code_a;
      chk("sine start", 32'(smp[0]), 32'h200);
      for (int k = 1; k < 17; k++) begin
         wait_tick();
         step(3);
         smp[k] = code_a;
      end
      chk("sine period", 32'(smp[16]), 32'h200);
      chk("sine peak", 32'(smp[4] > smp[0]), 32'h1);
      chk("sine trough", 32'(smp[12] < smp[0]), 32'h1);
      wr(dacc_pkg::OFS_CTRL_A, 32'h1, dacc_pkg::RESP_OKAY);
      wr(dacc_pkg::OFS_CTRL_A, 32'h49, dacc_pkg::RESP_OKAY);
      step(3);
      chk("sine restart", ca, 32'h200);
      // Differential, inverted sine on B, both DMA requests at once
      wr(dacc_pkg::OFS_CTRL_B, 32'h69, dacc_pkg::RESP_OKAY);
      wait_tick();
      step(3);
      chk("diff mode", 32'(diff), 32'h1);
      chk("diff b", cb, {22'h0, ~code_a});
      chk("pad b diff", 32'(pad_b), 32'h1);
      chk("dma both", 32'(req), 32'h3);
      wr(dacc_pkg::OFS_CTRL_B, 32'h0, dacc_pkg::RESP_OKAY);
      wr(dacc_pkg::OFS_CTRL_A, 32'h0, dacc_pkg::RESP_OKAY);
      step(2);
      chk("power off", 32'(pwr), 32'h0);
      chk("code b off", cb, 32'h0);
      $display("test sine done");
      end_sim();
   end
endmodule
